// File: design/ced_top.sv
// top: comparator control/status register, port 3 view, interrupts and power gating
//
// Behaviour
// - enable bit activates comparator; clear forces output low and blocks events.
// - port 3 pin reads return live comparator output in bit 6.
// - port 3 bit 6 writes change only the latch, not the comparator.
// - flag set when output meets selected mode; mode zero is low level.
// - flag stays set until software clears it; pollable or interrupting.
// - flag raises cmp_irq only while irq enable bit 6 is set; irq follows the status flag and mask, not bit 6.
// - comparator output sampled once every clock.
// - debounced modes wait two timer overflows, resample, set flag on match.
// - run-in-idle keeps comparator running in idle; otherwise powered down.
// - run-in-idle plus irq enable lets an event wake from idle.
// - comparator and detection always off in power-down.
// - mode encodings for edge, toggle, debounced and high-level conditions.
`timescale 1ns/1ps
module ced_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  // analog core and timer
  input  wire logic        cmp_raw,
  input  wire logic        timer_ovf,
  output logic             cmp_power_en,
  // port 3 pins
  input  wire logic [7:0]  port3_pins,
  output logic      [7:0]  port3_latch,
  // interrupts and wake
  output logic             cmp_irq,
  output logic             wake_req,
  output logic             irq
);
  import ced_pkg::*;

  logic [7:0] csr_ff;
  logic [7:0] ien_ff;
  logic [7:0] port_ff;
  logic [1:0] pwr_ff;
  logic [CED_NUM_EVT-1:0] status_ff;
  logic [CED_NUM_EVT-1:0] mask_ff;
  logic [31:0] rdata_ff;
  logic        ack_ff;
  logic [1:0]  rsp_ff;
  logic        waitreq_ff;
  logic        cmp_irq_ff;
  logic        wake_ff;
  logic        irq_ff;
  logic        pwr_en_ff;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: first stage feeds only the second
  logic cmp_s1_ff, cmp_s2_ff, ovf_s1_ff, ovf_s2_ff, ovf_d_ff;
  logic [7:0] pin_s1_ff, pin_s2_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      ovf_s1_ff <= 1'b0;
      ovf_s2_ff <= 1'b0;
      ovf_d_ff  <= 1'b0;
      pin_s1_ff <= 8'h00;
      pin_s2_ff <= 8'h00;
    end else begin
      cmp_s1_ff <= cmp_raw;
      cmp_s2_ff <= cmp_s1_ff;
      ovf_s1_ff <= timer_ovf;
      ovf_s2_ff <= ovf_s1_ff;
      ovf_d_ff  <= ovf_s2_ff;
      pin_s1_ff <= port3_pins;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power gating and gated comparator output
  logic in_idle, in_pd, active, cmp_out;
  assign in_idle = pwr_ff[CED_IDLE_BIT];
  assign in_pd   = pwr_ff[CED_PD_BIT];
  assign active  = csr_ff[CED_CEN_BIT] && !in_pd
                   && (!in_idle || csr_ff[CED_RUN_IN_IDLE_BIT]);
  assign cmp_out = active & cmp_s2_ff;

  ced_evt_if evt_if ();
  assign evt_if.active    = active;
  assign evt_if.sample    = cmp_out;
  assign evt_if.timer_ovf = ovf_s2_ff & ~ovf_d_ff;  // one pulse per overflow
  assign evt_if.mode      = ced_mode_type'(csr_ff[CED_CM_LSB +: 3]);

  ced_detect u_detect (
    .clk   (clk),
    .rst_n (rst_n),
    .evt   (evt_if.det)
  );

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one cycle wait, answer on the second edge
  logic req, take, wr, rd;
  assign req  = avs_read | avs_write;
  assign take = req & ack_ff;
  assign wr   = take & avs_write;
  assign rd   = take & avs_read;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] be);
    return be[0] ? d[7:0] : old;
  endfunction : merge

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // registered copy so the pin comes straight from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_ff <= 1'b1;
    end else begin
      waitreq_ff <= ~(req & ~ack_ff);
    end
  end

  // software-written control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ien_ff  <= 8'h00;
      port_ff <= CED_PORT_RESET;
      pwr_ff  <= 2'h0;
      mask_ff <= '0;
    end else if (wr) begin
      if (avs_address == CED_IRQ_EN_IDX) begin
        ien_ff <= merge(ien_ff, avs_writedata, avs_byteenable);
      end else if (avs_address == CED_PORT3_IDX) begin
        port_ff <= merge(port_ff, avs_writedata, avs_byteenable);
      end else if (avs_address == CED_MASK_IDX && avs_byteenable[0]) begin
        mask_ff <= avs_writedata[CED_NUM_EVT-1:0];
      end else if (avs_address == CED_PWR_IDX && avs_byteenable[0]) begin
        pwr_ff <= avs_writedata[1:0];
      end
    end else if (wake_ff) begin
      pwr_ff[CED_IDLE_BIT] <= 1'b0;
    end
  end

  // csr: control bits written; flag set by hardware, set wins over clear
  logic csr_wr;
  assign csr_wr = wr && avs_address == CED_CSR_IDX && avs_byteenable[0];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csr_ff <= CED_CSR_RESET;
    end else begin
      if (csr_wr) begin
        csr_ff[CED_RUN_IN_IDLE_BIT:0] <= avs_writedata[CED_RUN_IN_IDLE_BIT:0] & CED_CSR_WMASK[5:0];
        csr_ff[CED_CF_BIT] <= (avs_writedata[CED_CF_BIT] & csr_ff[CED_CF_BIT])
                              | evt_if.event_hit;
      end else if (evt_if.event_hit) begin
        csr_ff[CED_CF_BIT] <= 1'b1;
      end
    end
  end

  // sticky status, write one to clear, set wins
  logic [CED_NUM_EVT-1:0] evt_set;
  logic [CED_NUM_EVT-1:0] evt_clr;
  assign evt_set[CED_EVT_FLAG] = evt_if.event_hit;
  assign evt_set[CED_EVT_WAKE] = wake_ff;
  assign evt_clr = (wr && avs_address == CED_STATUS_IDX && avs_byteenable[0]) ?
                   avs_writedata[CED_NUM_EVT-1:0] : '0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~evt_clr) | evt_set;
    end
  end

  // read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
      rsp_ff   <= 2'b00;
    end else if (req && !ack_ff) begin
      rdata_ff <= 32'h0000_0000;
      rsp_ff   <= 2'b00;
      if (avs_address == CED_CSR_IDX) begin
        rdata_ff[7:0] <= csr_ff & CED_CSR_WMASK | (csr_ff & 8'h10);
      end else if (avs_address == CED_IRQ_EN_IDX) begin
        rdata_ff[7:0] <= ien_ff;
      end else if (avs_address == CED_PORT3_IDX) begin
        rdata_ff[7:0] <= {pin_s2_ff[7], cmp_out, pin_s2_ff[5:0]};
      end else if (avs_address == CED_STATUS_IDX) begin
        rdata_ff[CED_NUM_EVT-1:0] <= status_ff;
      end else if (avs_address == CED_MASK_IDX) begin
        rdata_ff[CED_NUM_EVT-1:0] <= mask_ff;
      end else if (avs_address == CED_PWR_IDX) begin
        rdata_ff[1:0] <= pwr_ff;
      end else begin
        rsp_ff <= 2'b11;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt, wake and outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_irq_ff <= 1'b0;
      wake_ff    <= 1'b0;
      irq_ff     <= 1'b0;
      pwr_en_ff  <= 1'b0;
    end else begin
      cmp_irq_ff <= csr_ff[CED_CF_BIT] & ien_ff[CED_EC_BIT];
      wake_ff    <= in_idle & csr_ff[CED_RUN_IN_IDLE_BIT] & ien_ff[CED_EC_BIT]
                    & evt_if.event_hit;
      irq_ff     <= |(status_ff & mask_ff);
      pwr_en_ff  <= active;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign avs_response    = rsp_ff;
  assign port3_latch     = port_ff;
  assign cmp_irq         = cmp_irq_ff;
  assign wake_req        = wake_ff;
  assign irq             = irq_ff;
  assign cmp_power_en    = pwr_en_ff;

  ////////////////////////////////////////////////////////////////////////////
  flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    csr_ff[CED_CF_BIT] && !csr_wr |=> csr_ff[CED_CF_BIT])
    else $error("event flag dropped without software clear");
  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmp_irq_ff |-> $past(csr_ff[CED_CF_BIT]) && $past(ien_ff[CED_EC_BIT]))
    else $error("comparator irq without flag and enable");
  pd_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    in_pd |=> !pwr_en_ff)
    else $error("comparator powered in power-down");
  idle_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    in_idle && !csr_ff[CED_RUN_IN_IDLE_BIT] |-> !active)
    else $error("comparator active in idle without run-in-idle");
  disabled_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    !csr_ff[CED_CEN_BIT] |-> !cmp_out ##1 !evt_if.event_hit)
    else $error("disabled comparator output or event");
  port_bit6_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd && avs_address == CED_PORT3_IDX |-> avs_readdata[CED_CMPOUT_BIT] == $past(cmp_out))
    else $error("port read does not show comparator output");

  sequence wake_evt_s;
    in_idle && csr_ff[CED_RUN_IN_IDLE_BIT] && ien_ff[CED_EC_BIT] && evt_if.event_hit;
  endsequence

  wait_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    req && !ack_ff |=> !avs_waitrequest)
    else $error("request not answered after one wait");
  wait_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !req |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt_if.event_hit |=> csr_ff[CED_CF_BIT])
    else $error("event did not set the flag");
  cmp_irq_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    csr_ff[CED_CF_BIT] && ien_ff[CED_EC_BIT] |=> cmp_irq_ff)
    else $error("comparator irq missing with flag and enable");
  irq_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    !csr_ff[CED_CF_BIT] |=> !cmp_irq_ff)
    else $error("comparator irq without flag");
  wake_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    wake_evt_s |=> wake_ff)
    else $error("event in idle did not wake");
  wake_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    wake_ff && !wr |=> !in_idle)
    else $error("wake did not leave idle");
  latch_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr && avs_address == CED_PORT3_IDX && avs_byteenable[0]
    |=> port3_latch == $past(avs_writedata[7:0]))
    else $error("port latch not written");
  latch_no_cmp_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr && avs_address == CED_PORT3_IDX
    |=> $stable(csr_ff[CED_CEN_BIT:0]) && $stable(csr_ff[CED_RUN_IN_IDLE_BIT]))
    else $error("port write changed comparator control");
  pend_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    !active |=> !evt_if.pending)
    else $error("debounce still pending while inactive");
  run_idle_pwr_a: assert property (@(posedge clk) disable iff (!rst_n)
    in_idle && !in_pd && csr_ff[CED_CEN_BIT] && csr_ff[CED_RUN_IN_IDLE_BIT] |=> cmp_power_en)
    else $error("comparator off in idle with run-in-idle");
  status_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    status_ff[CED_EVT_FLAG] && !evt_clr[CED_EVT_FLAG] |=> status_ff[CED_EVT_FLAG])
    else $error("status bit dropped without clear");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    |(status_ff & mask_ff) |=> irq)
    else $error("irq low with unmasked status");
  unmapped_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd && avs_address > CED_PWR_IDX |-> avs_response == 2'b11)
    else $error("unmapped read without error response");
  pd_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    in_pd |=> !evt_if.event_hit)
    else $error("event detected in power-down");
endmodule : ced_top

// File: design/ced_pkg.sv
// package: register map, field layout and timing constants for the comparator event block
package ced_pkg;
  // avalon word addresses (byte address / 4)
  localparam logic [3:0] CED_CSR_IDX      = 4'h0;  // comparator_control_status
  localparam logic [3:0] CED_IRQ_EN_IDX   = 4'h1;  // interrupt_enable_reg
  localparam logic [3:0] CED_PORT3_IDX    = 4'h2;  // port 3 latch / pin read
  localparam logic [3:0] CED_STATUS_IDX   = 4'h3;  // sticky event status, w1c
  localparam logic [3:0] CED_MASK_IDX     = 4'h4;  // interrupt mask
  localparam logic [3:0] CED_PWR_IDX      = 4'h5;  // idle / power-down request
  localparam logic [7:0] CED_CSR_OFFSET   = 8'h97;

  // csr, irq enable, port 3, power and status bit fields
  localparam int CED_CM_LSB     = 0;
  localparam int CED_CEN_BIT    = 3;
  localparam int CED_CF_BIT     = 4;
  localparam int CED_RUN_IN_IDLE_BIT   = 5;
  localparam int CED_EC_BIT     = 6;
  localparam int CED_CMPOUT_BIT = 6;
  localparam int CED_IDLE_BIT   = 0;
  localparam int CED_PD_BIT     = 1;
  localparam int CED_NUM_EVT    = 2;
  localparam int CED_EVT_FLAG   = 0;
  localparam int CED_EVT_WAKE   = 1;

  localparam logic [7:0] CED_CSR_RESET  = 8'h00;
  localparam logic [7:0] CED_PORT_RESET = 8'hFF;
  localparam logic [7:0] CED_CSR_WMASK  = 8'h2F;

  // debounce waits this many timer overflows
  localparam int CED_DEB_OVF = 2;

  // settle time (software obligation, kept for reference)
  localparam int CED_CLK_MHZ    = 100;
  localparam int CED_SETTLE_US  = 10;
  localparam int CED_SETTLE_CYC = CED_SETTLE_US * CED_CLK_MHZ;

  typedef enum logic [2:0] {
    CED_LOW_LEVEL = 3'b000,
    CED_POS_EDGE  = 3'b001,
    CED_TOG_DEB   = 3'b010,
    CED_POS_DEB   = 3'b011,
    CED_NEG_EDGE  = 3'b100,
    CED_TOGGLE    = 3'b101,
    CED_NEG_DEB   = 3'b110,
    CED_HIGH_LVL  = 3'b111
  } ced_mode_type;
endpackage : ced_pkg

// File: design/ced_evt_if.sv
// interface: detector configuration and event result between top and detector
`timescale 1ns/1ps
interface ced_evt_if;
  logic               active;
  logic               sample;
  logic               timer_ovf;
  ced_pkg::ced_mode_type mode;
  logic               event_hit;
  logic               pending;
  modport ctrl (output active, output sample, output timer_ovf, output mode,
                input event_hit, input pending);
  modport det  (input active, input sample, input timer_ovf, input mode,
                output event_hit, output pending);
endinterface : ced_evt_if

// File: design/ced_detect.sv
// detector: level, edge, toggle and debounced condition evaluation
`timescale 1ns/1ps
module ced_detect (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // detector link
  ced_evt_if.det   evt
);
  import ced_pkg::*;

  typedef enum logic [1:0] {CED_IDLE_S, CED_WAIT_S} ced_deb_type;

  logic        prev_ff;
  ced_deb_type deb_ff;
  logic [1:0]  ovf_cnt_ff;
  logic        expect_ff;
  logic        hit_ff;

  function automatic logic is_debounced(input ced_mode_type m);
    return (m == CED_TOG_DEB) || (m == CED_POS_DEB) || (m == CED_NEG_DEB);
  endfunction : is_debounced

  logic rise;
  logic fall;
  logic raw_hit;
  logic trans;
  assign rise = evt.sample & ~prev_ff;
  assign fall = ~evt.sample & prev_ff;

  always_comb begin
    raw_hit = 1'b0;
    trans   = 1'b0;
    case (evt.mode)
      CED_LOW_LEVEL: raw_hit = ~evt.sample;
      CED_POS_EDGE:  raw_hit = rise;
      CED_NEG_EDGE:  raw_hit = fall;
      CED_TOGGLE:    raw_hit = rise | fall;
      CED_HIGH_LVL:  raw_hit = evt.sample;
      CED_TOG_DEB:   trans   = rise | fall;
      CED_POS_DEB:   trans   = rise;
      CED_NEG_DEB:   trans   = fall;
      default:       raw_hit = 1'b0;
    endcase
  end

  // one sample per clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= evt.sample;
    end
  end

  // debounce: a fresh transition while waiting is ignored, the first one stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deb_ff     <= CED_IDLE_S;
      ovf_cnt_ff <= 2'h0;
      expect_ff  <= 1'b0;
    end else if (!evt.active || !is_debounced(evt.mode)) begin
      deb_ff     <= CED_IDLE_S;
      ovf_cnt_ff <= 2'h0;
    end else begin
      case (deb_ff)
        CED_IDLE_S: begin
          if (trans) begin
            deb_ff     <= CED_WAIT_S;
            ovf_cnt_ff <= 2'h0;
            expect_ff  <= evt.sample;
          end
        end
        CED_WAIT_S: begin
          if (evt.timer_ovf) begin
            if (ovf_cnt_ff == 2'(CED_DEB_OVF - 1)) begin
              deb_ff     <= CED_IDLE_S;
              ovf_cnt_ff <= 2'h0;
            end else begin
              ovf_cnt_ff <= ovf_cnt_ff + 2'h1;
            end
          end
        end
        default: deb_ff <= CED_IDLE_S;
      endcase
    end
  end

  logic deb_hit;
  assign deb_hit = (deb_ff == CED_WAIT_S) && evt.timer_ovf &&
                   (ovf_cnt_ff == 2'(CED_DEB_OVF - 1)) && (evt.sample == expect_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= evt.active && (is_debounced(evt.mode) ? deb_hit : raw_hit);
    end
  end

  assign evt.event_hit = hit_ff;
  assign evt.pending   = (deb_ff == CED_WAIT_S);

  ////////////////////////////////////////////////////////////////////////////
  sequence ovf_s;
    evt.timer_ovf;
  endsequence

  pos_edge_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt.active && evt.mode == CED_POS_EDGE && rise |=> hit_ff)
    else $error("positive edge not reported");
  low_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt.active && evt.mode == CED_LOW_LEVEL && !evt.sample |=> hit_ff)
    else $error("low level not reported");
  inactive_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !evt.active |=> !hit_ff)
    else $error("event while disabled");
  deb_no_early_a: assert property (@(posedge clk) disable iff (!rst_n)
    deb_ff == CED_IDLE_S && evt.active && trans ##1
    (!evt.timer_ovf && evt.active && is_debounced(evt.mode))
    |=> !hit_ff)
    else $error("debounced event before two overflows");
  deb_abandon_a: assert property (@(posedge clk) disable iff (!rst_n)
    !evt.active |=> deb_ff == CED_IDLE_S)
    else $error("debounce not abandoned");
  deb_second_ovf_a: assert property (@(posedge clk) disable iff (!rst_n)
    (deb_ff == CED_WAIT_S && ovf_cnt_ff == 2'h1 && evt.active &&
    is_debounced(evt.mode)) and ovf_s |=> deb_ff == CED_IDLE_S)
    else $error("debounce did not resample on second overflow");
endmodule : ced_detect

// File: dv/ced_cmp_model.sv
// partner model: analog comparator core and free-running overflow timer
`timescale 1ns/1ps
module ced_cmp_model #(
  parameter int PERIOD = 20
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // power and analog level
  input  wire logic power_en,
  input  wire logic level,
  // towards the design
  output logic      cmp_raw,
  output logic      timer_ovf
);
  logic [7:0] cnt_ff;
  logic       junk_ff;
  ////////////////////////////////////////////////////////////////////////////
  // timer runs free, overflow pulse one cycle per period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff    <= 8'h00;
      timer_ovf <= 1'b0;
    end else begin
      cnt_ff    <= (cnt_ff == 8'(PERIOD - 1)) ? 8'h00 : cnt_ff + 8'h01;
      timer_ovf <= (cnt_ff == 8'(PERIOD - 1));
    end
  end
  // unpowered core wanders, so gating in the design must be real
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) junk_ff <= 1'b0;
    else junk_ff <= ~junk_ff;
  end
  assign cmp_raw = power_en ? level : junk_ff;
endmodule : ced_cmp_model

// File: dv/comparator_event_debounce_bench.sv
// bench: random and corner tests of the comparator event block
`timescale 1ns/1ps
module comparator_event_debounce_bench;
  import ced_pkg::*;
  localparam int PER   = 20;
  localparam int LIMIT = 20000;
  logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0]  avs_response, rsp;
  logic        cmp_raw, timer_ovf, cmp_power_en, cmp_irq, wake_req, irq;
  logic [7:0]  port3_pins, port3_latch, v;
  logic        level, wake_seen, a, b, en, f, mk;
  logic [2:0]  m;
  logic [2:0]  lm [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h7};
  logic [2:0]  dm [6] = '{3'h3, 3'h6, 3'h2, 3'h6, 3'h3, 3'h6};
  logic        da [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic        dg [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int          mismatches, compares, cycles;

  ced_top dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .cmp_raw(cmp_raw), .timer_ovf(timer_ovf),
    .cmp_power_en(cmp_power_en), .port3_pins(port3_pins), .port3_latch(port3_latch),
    .cmp_irq(cmp_irq), .wake_req(wake_req), .irq(irq));
  ced_cmp_model #(.PERIOD(PER)) far_u (.clk(clk), .rst_n(rst_n), .power_en(cmp_power_en),
    .level(level), .cmp_raw(cmp_raw), .timer_ovf(timer_ovf));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // wake is a one-cycle pulse, so it is caught here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wake_req === 1'b1) wake_seen <= 1'b1;
    if (cycles == LIMIT) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // one avalon access, held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [3:0] idx, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= idx;
    avs_writedata <= {24'h000000, data};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd  = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check("wait states", 32'(n), 32'h2);
  endtask : access
  task automatic bus_wr(input logic [3:0] idx, input logic [7:0] data);
    access(1'b1, idx, data);
  endtask : bus_wr
  task automatic bus_rd(input logic [3:0] idx);
    access(1'b0, idx, 8'h00);
  endtask : bus_rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc
  function automatic logic exp_flag(input logic [2:0] md, input logic x, input logic y);
    case (md)
      3'h0: return ~x | ~y;
      3'h7: return x | y;
      3'h1: return ~x & y;
      3'h4: return x & ~y;
      default: return x ^ y;
    endcase
  endfunction : exp_flag
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, avs_read, avs_write, level, wake_seen} = 5'h00;
    {avs_address, avs_writedata, port3_pins} = 44'h0;
    avs_byteenable = 4'h1;
    {mismatches, compares, cycles} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(32'hBD85F6DE));
    // reset values, readback mask, unmapped read
    bus_rd(CED_CSR_IDX);
    check("csr reset", rd, 32'(CED_CSR_RESET));
    check("latch reset", 32'(port3_latch), 32'(CED_PORT_RESET));
    bus_wr(CED_CSR_IDX, 8'hF7);
    bus_rd(CED_CSR_IDX);
    check("csr mask", rd, 32'h27);
    bus_rd(4'hF);
    check("unmapped", {30'(rd), rsp}, 32'h3);
    bus_wr(CED_CSR_IDX, 8'h0F);
    wait_cyc(CED_SETTLE_CYC);
    bus_wr(CED_CSR_IDX, 8'h0F);
    bus_wr(CED_IRQ_EN_IDX, 8'h40);
    $display("test reset done");
    // random non-debounced modes, enable, mask and port view
    for (int i = 0; i < 24; i++) begin
      m = lm[$urandom_range(4)];
      {a, b, mk} = 3'($urandom);
      en = ($urandom_range(3) != 0);
      port3_pins <= 8'($urandom);
      level <= a;
      bus_wr(CED_MASK_IDX, {7'h00, mk});
      bus_wr(CED_CSR_IDX, {4'h0, en, m});
      wait_cyc(8);
      bus_wr(CED_CSR_IDX, {4'h0, en, m});
      bus_wr(CED_STATUS_IDX, 8'h03);
      level <= b;
      v = {~b, 7'($urandom)};
      bus_wr(CED_PORT3_IDX, v);
      wait_cyc(8);
      check("latch", 32'(port3_latch), 32'(v));
      f = en & ((m == 3'h0 || m == 3'h7) ? exp_flag(m, a, b) : exp_flag(m, a, b));
      bus_rd(CED_CSR_IDX);
      check("csr", rd, {27'h0, f, en, m});
      bus_rd(CED_STATUS_IDX);
      check("status", 32'(rd[0]), 32'(f));
      check("cmp_irq", 32'(cmp_irq), 32'(f));
      check("irq", 32'(irq), 32'(f & mk));
      bus_rd(CED_PORT3_IDX);
      check("pins", rd, {24'h0, port3_pins[7], en & b, port3_pins[5:0]});
    end
    $display("test modes done");
    // debounced modes: hold, glitch, disable while waiting
    for (int k = 0; k < 6; k++) begin
      level <= da[k];
      bus_wr(CED_CSR_IDX, {4'h1, dm[k]});
      wait_cyc(3 * PER);
      bus_wr(CED_CSR_IDX, {4'h1, dm[k]});
      level <= ~da[k];
      wait_cyc(3);
      if (dg[k]) level <= da[k];
      if (k == 5) bus_wr(CED_CSR_IDX, {5'h00, dm[k]});
      bus_rd(CED_CSR_IDX);
      check("deb early", 32'(rd[4]), 32'h0);
      wait_cyc(3 * PER);
      bus_rd(CED_CSR_IDX);
      check("deb flag", 32'(rd[4]), 32'(~dg[k] & (k != 5)));
    end
    $display("test debounce done");
    // idle with and without run-in-idle, then power-down
    wake_seen = 1'b0;
    level <= 1'b0;
    bus_wr(CED_CSR_IDX, 8'h29);
    wait_cyc(8);
    bus_wr(CED_CSR_IDX, 8'h29);
    bus_wr(CED_PWR_IDX, 8'h01);
    wait_cyc(2);
    check("power idle run", 32'(cmp_power_en), 32'h1);
    level <= 1'b1;
    wait_cyc(10);
    check("wake", 32'(wake_seen), 32'h1);
    bus_rd(CED_PWR_IDX);
    check("idle left", rd, 32'h0);
    bus_wr(CED_CSR_IDX, 8'h09);
    bus_wr(CED_PWR_IDX, 8'h01);
    wait_cyc(2);
    check("power idle", 32'(cmp_power_en), 32'h0);
    bus_wr(CED_PWR_IDX, 8'h02);
    bus_wr(CED_CSR_IDX, 8'h29);
    level <= 1'b0;
    wait_cyc(4);
    level <= 1'b1;
    wait_cyc(3 * PER);
    check("power down", 32'(cmp_power_en), 32'h0);
    bus_rd(CED_CSR_IDX);
    check("pd flag", 32'(rd[4]), 32'h0);
    bus_wr(CED_PWR_IDX, 8'h00);
    $display("test power done");
    close_out();
  end
endmodule : comparator_event_debounce_bench
